/* File: design/osc_output_ctrl.sv */
// register bank and control for the analog playback output stages
// assumes a register port driven by the serial control logic on mclk,
// and raw short-circuit detector levels from the headphone drivers
//
// Behaviour
// R01: volume code maps to rising attenuation
// R02: mute when route off and code 127
// R03: soft-step interval from page-0 two-bit field
// R04: dac routed to volume controls by bits
// R05: speaker volume codes from registers 38, 39
// R06: volume output feeds speaker when bit7 set
// R07: line-out drive mode when field is three
// R08: common-mode level from bits 4 to 3
// R09: headphone drivers powered by bits 7, 6
// R10: headphone gain and mute per channel
// R11: short limits current or powers down
// R12: current limiting is the reset default
// R13: read-only short flag at bit 0
// R14: shutdown mode clears affected power bit
// R15: pin or software reset restores defaults
// R16: setting power bit again restarts stage
// R17: restarted stage shuts again if short remains
// R18: software avoids more than three restarts
// R19: short detection is always active
// R20: applied code steps toward target, then holds
`include "osc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module osc_output_ctrl #(
  parameter int CNT_W = 12
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // register port
  input  wire logic       reg_page,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_r,
  // short-circuit detectors, asynchronous
  input  wire logic       hp_short_l,
  input  wire logic       hp_short_r,
  // headphone stage controls
  output logic            left_headphone_out_pwr_r,
  output logic            right_headphone_out_pwr_r,
  output logic      [3:0] left_headphone_out_gain_r,
  output logic      [3:0] right_headphone_out_gain_r,
  output logic            left_headphone_out_mute_r,
  output logic            right_headphone_out_mute_r,
  output logic            left_headphone_out_ilim_r,
  output logic            right_headphone_out_ilim_r,
  output logic      [1:0] hp_common_mode_r,
  output logic            hp_lineout_mode_r,
  // routing and speaker volume
  output logic            dac_route_l_r,
  output logic            dac_route_r_r,
  output logic            spk_feed_l_r,
  output logic            spk_feed_r_r,
  output logic      [6:0] spk_vol_l_r,
  output logic      [6:0] spk_vol_r_r,
  output logic      [9:0] spk_atten_l_r,
  output logic      [9:0] spk_atten_r_r,
  output logic            spk_mute_l_r,
  output logic            spk_mute_r_r
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // attenuation in tenths of a dB for a volume code
  function automatic logic [9:0] osc_atten(input logic [6:0] code);
    logic [9:0] lin;
    lin = 10'({3'h0, code} * 10'd5);
    if (code >= 7'd117)      osc_atten = 10'd783;
    else if (code == 7'd116) osc_atten = 10'd722;
    else if (code == 7'd115) osc_atten = 10'd687;
    else if (code == 7'd114) osc_atten = 10'd662;
    else if (code == 7'd113) osc_atten = 10'd643;
    else if (code == 7'd112) osc_atten = 10'd627;
    else if (code == 7'd111) osc_atten = 10'd602;
    else if (code == 7'd110) osc_atten = 10'd583;
    else if (code == 7'd109) osc_atten = 10'd567;
    else if (code == 7'd108) osc_atten = 10'd553;
    else if (code == 7'd107) osc_atten = 10'd542;
    else if (code == 7'd106) osc_atten = 10'd537;
    else osc_atten = lin + {9'h0, code > 7'd35} + {9'h0, code > 7'd69};
  endfunction : osc_atten

  // step interval in clocks for a soft-step field
  function automatic logic [CNT_W-1:0] osc_step(input logic [1:0] sel);
    case (sel)
      2'h0:    osc_step = CNT_W'(`OSC_SS_STEP_CYC);
      2'h1:    osc_step = CNT_W'(2 * `OSC_SS_STEP_CYC);
      2'h2:    osc_step = CNT_W'(4 * `OSC_SS_STEP_CYC);
      default: osc_step = '0;
    endcase
  endfunction : osc_step

  // ****************************************************************
  // short detector synchronisers
  // ****************************************************************
  logic [1:0] short_meta_r;
  logic [1:0] short_r;

  // two flops before any logic sees the detectors
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      short_meta_r <= 2'h0;
      short_r      <= 2'h0;
    end else begin
      short_meta_r <= {hp_short_r, hp_short_l};
      short_r      <= short_meta_r; // R19
    end
  end

  // ****************************************************************
  // register decode
  // ****************************************************************
  logic [7:0] hp_ctrl_r;
  logic [7:0] route_r;
  logic [7:0] spk_l_r;
  logic [7:0] spk_r_r;
  logic [7:0] hpg_l_r;
  logic [7:0] hpg_r_r;
  logic [7:0] hp_opt_r;
  logic [7:0] ss_ctrl_r;
  logic       sw_rst_r;

  wire        wr_p0     = reg_wr & ~reg_page;
  wire        wr_p1     = reg_wr & reg_page;
  wire        we_hp     = wr_p1 & (reg_addr == `OSC_OFS_HP_CTRL);
  wire        we_route  = wr_p1 & (reg_addr == `OSC_OFS_ROUTE);
  wire        we_spk_l  = wr_p1 & (reg_addr == `OSC_OFS_SPK_L);
  wire        we_spk_r  = wr_p1 & (reg_addr == `OSC_OFS_SPK_R);
  wire        we_hpg_l  = wr_p1 & (reg_addr == `OSC_OFS_HPG_L);
  wire        we_hpg_r  = wr_p1 & (reg_addr == `OSC_OFS_HPG_R);
  wire        we_opt    = wr_p1 & (reg_addr == `OSC_OFS_HP_OPT);
  wire        we_ss     = wr_p0 & (reg_addr == `OSC_OFS_SS_CTRL);
  wire        we_swrst  = wr_p0 & (reg_addr == `OSC_OFS_SW_RST)
                          & reg_wdata[`OSC_BIT_SWRST];
  wire        bank_rst  = !rst_b || sw_rst_r; // R15
  wire        sc_mode   = hp_ctrl_r[`OSC_BIT_SC_MODE];
  wire        sc_flag   = short_r[0] | short_r[1]; // R13
  // shutdown mode drops the power bit of a shorted channel
  wire        trip_l    = sc_mode & short_r[0]; // R14
  wire        trip_r    = sc_mode & short_r[1]; // R14

  // headphone control: power bits written by software, cleared on a trip
  logic [7:0] hp_ctrl_nxt;
  always_comb begin
    hp_ctrl_nxt = we_hp ? {reg_wdata[7:1], 1'b0} : hp_ctrl_r; // R16
    if (trip_l) hp_ctrl_nxt[`OSC_BIT_PWR_L] = 1'b0; // R17
    if (trip_r) hp_ctrl_nxt[`OSC_BIT_PWR_R] = 1'b0; // R17
  end

  // read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (reg_page) begin
      case (reg_addr)
        `OSC_OFS_HP_CTRL: rd_mux = {hp_ctrl_r[7:1], sc_flag}; // R13
        `OSC_OFS_ROUTE:   rd_mux = route_r;
        `OSC_OFS_SPK_L:   rd_mux = spk_l_r;
        `OSC_OFS_SPK_R:   rd_mux = spk_r_r;
        `OSC_OFS_HPG_L:   rd_mux = hpg_l_r;
        `OSC_OFS_HPG_R:   rd_mux = hpg_r_r;
        `OSC_OFS_HP_OPT:  rd_mux = hp_opt_r;
        default:          rd_mux = 8'h00;
      endcase
    end else if (reg_addr == `OSC_OFS_SS_CTRL) begin
      rd_mux = ss_ctrl_r;
    end
  end

  // ****************************************************************
  // register bank
  // ****************************************************************
  // software reset pulse, taken one clock after its write
  always_ff @(posedge mclk) begin
    if (!rst_b) sw_rst_r <= 1'b0;
    else        sw_rst_r <= we_swrst; // R15
  end

  // all registers return to defaults on either reset
  always_ff @(posedge mclk) begin
    if (bank_rst) begin
      hp_ctrl_r <= `OSC_RST_REG; // R12
      route_r   <= `OSC_RST_REG;
      spk_l_r   <= `OSC_RST_REG;
      spk_r_r   <= `OSC_RST_REG;
      hpg_l_r   <= `OSC_RST_REG;
      hpg_r_r   <= `OSC_RST_REG;
      hp_opt_r  <= `OSC_RST_REG;
      ss_ctrl_r <= `OSC_RST_REG;
    end else begin
      hp_ctrl_r <= hp_ctrl_nxt;
      if (we_route) route_r   <= reg_wdata;
      if (we_spk_l) spk_l_r   <= reg_wdata;
      if (we_spk_r) spk_r_r   <= reg_wdata;
      if (we_hpg_l) hpg_l_r   <= reg_wdata;
      if (we_hpg_r) hpg_r_r   <= reg_wdata;
      if (we_opt)   hp_opt_r  <= reg_wdata;
      if (we_ss)    ss_ctrl_r <= reg_wdata;
    end
  end

  // read data held until the next read
  always_ff @(posedge mclk) begin
    if (!rst_b)      reg_rdata_r <= 8'h00;
    else if (reg_rd) reg_rdata_r <= rd_mux;
  end

  // ****************************************************************
  // soft-stepped speaker volume
  // ****************************************************************
  wire [CNT_W-1:0] step_cyc = osc_step(ss_ctrl_r[`OSC_SS_HI:`OSC_SS_LO]); // R03
  logic [6:0]      vol_l;
  logic [6:0]      vol_r;

  osc_vol_ramp #(.CNT_W(CNT_W)) u_ramp_l (
    .mclk      (mclk),
    .rst_b     (!bank_rst),
    .target    (spk_l_r[`OSC_VOL_HI:0]), // R05
    .step_cyc  (step_cyc),
    .applied_r (vol_l),
    .moving_r  ()
  );

  osc_vol_ramp #(.CNT_W(CNT_W)) u_ramp_r (
    .mclk      (mclk),
    .rst_b     (!bank_rst),
    .target    (spk_r_r[`OSC_VOL_HI:0]), // R05
    .step_cyc  (step_cyc),
    .applied_r (vol_r),
    .moving_r  ()
  );

  // ****************************************************************
  // output stage
  // ****************************************************************
  wire mute_l = !spk_l_r[`OSC_BIT_SPK_EN] && (vol_l == `OSC_MUTE_CODE); // R02
  wire mute_r = !spk_r_r[`OSC_BIT_SPK_EN] && (vol_r == `OSC_MUTE_CODE); // R02
  wire pwr_l  = hp_ctrl_r[`OSC_BIT_PWR_L];
  wire pwr_r  = hp_ctrl_r[`OSC_BIT_PWR_R];

  // every output straight from a flop
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      left_headphone_out_pwr_r   <= 1'b0;
      right_headphone_out_pwr_r  <= 1'b0;
      left_headphone_out_gain_r  <= 4'h0;
      right_headphone_out_gain_r <= 4'h0;
      left_headphone_out_mute_r  <= 1'b0;
      right_headphone_out_mute_r <= 1'b0;
      left_headphone_out_ilim_r  <= 1'b0;
      right_headphone_out_ilim_r <= 1'b0;
      hp_common_mode_r           <= 2'h0;
      hp_lineout_mode_r          <= 1'b0;
      dac_route_l_r              <= 1'b0;
      dac_route_r_r              <= 1'b0;
      spk_feed_l_r               <= 1'b0;
      spk_feed_r_r               <= 1'b0;
      spk_vol_l_r                <= 7'h00;
      spk_vol_r_r                <= 7'h00;
      spk_atten_l_r              <= 10'h000;
      spk_atten_r_r              <= 10'h000;
      spk_mute_l_r               <= 1'b0;
      spk_mute_r_r               <= 1'b0;
    end else begin
      left_headphone_out_pwr_r   <= pwr_l; // R09
      right_headphone_out_pwr_r  <= pwr_r; // R09
      left_headphone_out_gain_r  <= hpg_l_r[`OSC_HPG_HI:`OSC_HPG_LO]; // R10
      right_headphone_out_gain_r <= hpg_r_r[`OSC_HPG_HI:`OSC_HPG_LO]; // R10
      left_headphone_out_mute_r  <= hpg_l_r[`OSC_BIT_HPG_MUTE]; // R10
      right_headphone_out_mute_r <= hpg_r_r[`OSC_BIT_HPG_MUTE]; // R10
      left_headphone_out_ilim_r  <= short_r[0] & !sc_mode & pwr_l; // R11
      right_headphone_out_ilim_r <= short_r[1] & !sc_mode & pwr_r; // R11
      hp_common_mode_r           <= hp_ctrl_r[`OSC_CM_HI:`OSC_CM_LO]; // R08
      hp_lineout_mode_r          <= (hp_opt_r[`OSC_OPT_HI:`OSC_OPT_LO]
                                     == `OSC_LINEOUT_CODE); // R07
      dac_route_l_r              <= route_r[`OSC_BIT_RT_L]; // R04
      dac_route_r_r              <= route_r[`OSC_BIT_RT_R]; // R04
      spk_feed_l_r               <= spk_l_r[`OSC_BIT_SPK_EN]; // R06
      spk_feed_r_r               <= spk_r_r[`OSC_BIT_SPK_EN]; // R06
      spk_vol_l_r                <= vol_l;
      spk_vol_r_r                <= vol_r;
      spk_atten_l_r              <= osc_atten(vol_l); // R01
      spk_atten_r_r              <= osc_atten(vol_r); // R01
      spk_mute_l_r               <= mute_l;
      spk_mute_r_r               <= mute_r;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_vol_atten_map : assert property (@(posedge mclk) disable iff (!rst_b) // R01
    (vol_l <= 7'd35) |=> (spk_atten_l_r == 10'({3'h0, $past(vol_l)} * 10'd5)))
    else $error("attenuation not half-dB per code");
  chk_mute_code : assert property (@(posedge mclk) disable iff (!rst_b) // R02
    (!spk_r_r[7] && vol_r == 7'h7F && !sw_rst_r) |=> spk_mute_r_r)
    else $error("muting code did not mute");
  chk_soft_off_jump : assert property (@(posedge mclk) disable iff (bank_rst) // R03
    (we_spk_l && ss_ctrl_r[1:0] == 2'h3 && !we_ss) |=> ##[1:3] (vol_l == spk_l_r[6:0]))
    else $error("volume did not jump with soft-step off");
  chk_route_left : assert property (@(posedge mclk) disable iff (bank_rst) // R04
    we_route |=> ##1 (dac_route_l_r == $past(reg_wdata[6], 2)))
    else $error("left dac route does not follow bit");
  chk_lineout_mode : assert property (@(posedge mclk) disable iff (bank_rst) // R07
    we_opt |=> ##1 (hp_lineout_mode_r == ($past(reg_wdata[2:1], 2) == 2'h3)))
    else $error("line-out mode does not follow field");
  chk_shutdown_clear : assert property (@(posedge mclk) disable iff (bank_rst) // R14
    (sc_mode && short_r[0]) |=> !hp_ctrl_r[7] ##1 !left_headphone_out_pwr_r)
    else $error("shorted left stage kept power");
  chk_limit_mode : assert property (@(posedge mclk) disable iff (bank_rst) // R11
    (!sc_mode && short_r[1] && pwr_r && !we_hp) |=> right_headphone_out_ilim_r && pwr_r)
    else $error("current limit not applied");
  chk_short_flag : assert property (@(posedge mclk) disable iff (!rst_b) // R13
    (reg_rd && reg_page && reg_addr == 7'h1F) |=> (reg_rdata_r[0] == $past(sc_flag)))
    else $error("short flag misreported");
  chk_sw_reset : assert property (@(posedge mclk) disable iff (!rst_b) // R15
    we_swrst |=> ##1 (hp_ctrl_r == 8'h00 && spk_l_r == 8'h00 && route_r == 8'h00))
    else $error("software reset left a register set");
  chk_restart_kept : assert property (@(posedge mclk) disable iff (bank_rst) // R16
    (we_hp && reg_wdata[7] && !trip_l) |=> hp_ctrl_r[7] && $stable(spk_l_r))
    else $error("power bit set did not restart stage");

endmodule : osc_output_ctrl

`default_nettype wire

/* File: design/osc_params.svh */
// constants for the analog output stage control block
// assumes a 10 MHz mclk; offsets are the 7-bit register numbers of each page
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OSC_OFS_SW_RST    7'h01
`define OSC_OFS_SS_CTRL   7'h3F
`define OSC_OFS_HP_CTRL   7'h1F
`define OSC_OFS_ROUTE     7'h23
`define OSC_OFS_SPK_L     7'h26
`define OSC_OFS_SPK_R     7'h27
`define OSC_OFS_HPG_L     7'h28
`define OSC_OFS_HPG_R     7'h29
`define OSC_OFS_HP_OPT    7'h2C

// ****************************************************************
// field positions
// ****************************************************************
`define OSC_BIT_SWRST     0
`define OSC_BIT_PWR_L     7
`define OSC_BIT_PWR_R     6
`define OSC_CM_HI         4
`define OSC_CM_LO         3
`define OSC_BIT_SC_MODE   1
`define OSC_BIT_SC_FLAG   0
`define OSC_BIT_RT_L      6
`define OSC_BIT_RT_R      2
`define OSC_BIT_SPK_EN    7
`define OSC_VOL_HI        6
`define OSC_HPG_HI        6
`define OSC_HPG_LO        3
`define OSC_BIT_HPG_MUTE  2
`define OSC_OPT_HI        2
`define OSC_OPT_LO        1
`define OSC_SS_HI         1
`define OSC_SS_LO         0

// ****************************************************************
// reset values and codes
// ****************************************************************
`define OSC_RST_REG       8'h00
`define OSC_MUTE_CODE     7'h7F
`define OSC_LINEOUT_CODE  2'h3
`define OSC_SS_OFF_CODE   2'h3

// ****************************************************************
// timing
// ****************************************************************
`define OSC_CLK_NS        100
`define OSC_SS_STEP_NS    20834
`define OSC_SS_STEP_CYC   ((`OSC_SS_STEP_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)

`endif

/* File: design/osc_pkg.sv */
// types shared by the output stage control files
// assumes nothing of its surroundings
package osc_pkg;

  // soft-step ramp states, one-hot
  typedef enum logic [1:0] {
    OSC_RAMP_HOLD = 2'b01,
    OSC_RAMP_MOVE = 2'b10
  } osc_ramp_state_t;

endpackage : osc_pkg

/* File: design/osc_vol_ramp.sv */
// soft-step ramp for one analog volume code
// assumes step_cyc is stable while a ramp runs; 0 means jump at once
`timescale 1ns/1ps
`default_nettype none

module osc_vol_ramp #(
  parameter int CNT_W = 12
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // control
  input  wire logic [6:0]        target,
  input  wire logic [CNT_W-1:0]  step_cyc,
  // applied code
  output logic      [6:0]        applied_r,
  output logic                   moving_r
);

  // ****************************************************************
  // step timing
  // ****************************************************************
  osc_pkg::osc_ramp_state_t state_r;
  osc_pkg::osc_ramp_state_t state_nxt;
  logic [CNT_W-1:0]         cnt_r;
  logic [CNT_W-1:0]         cnt_nxt;
  logic [6:0]               applied_nxt;
  wire                      differ  = (applied_r != target);
  wire                      tick    = (cnt_r == '0);
  wire                      go_up   = (applied_r < target);

  // state and applied code decision
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    applied_nxt = applied_r;
    case (state_r)
      osc_pkg::OSC_RAMP_HOLD: begin
        if (differ) begin
          state_nxt = osc_pkg::OSC_RAMP_MOVE;
          cnt_nxt   = step_cyc;
        end
      end
      osc_pkg::OSC_RAMP_MOVE: begin
        if (step_cyc == '0) begin
          applied_nxt = target; // soft-step off: jump
          state_nxt   = osc_pkg::OSC_RAMP_HOLD;
        end else if (!differ) begin
          state_nxt = osc_pkg::OSC_RAMP_HOLD;
        end else if (tick) begin
          applied_nxt = go_up ? applied_r + 7'h01 : applied_r - 7'h01; // R20
          cnt_nxt     = step_cyc;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: state_nxt = osc_pkg::OSC_RAMP_HOLD;
    endcase
  end

  // registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r   <= osc_pkg::OSC_RAMP_HOLD;
      cnt_r     <= '0;
      applied_r <= 7'h00;
      moving_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      applied_r <= applied_nxt;
      moving_r  <= (state_nxt == osc_pkg::OSC_RAMP_MOVE);
    end
  end

  // applied code moves at most one step per clock unless soft-step is off
  chk_ramp_one_step : assert property (@(posedge mclk) disable iff (!rst_b) // R20
    (step_cyc != '0) |=> (applied_r == $past(applied_r)) ||
      (applied_r == $past(applied_r) + 7'h01) || (applied_r == $past(applied_r) - 7'h01))
    else $error("volume ramp jumped more than one step");

endmodule : osc_vol_ramp

`default_nettype wire

/* File: tb/osc_hp_load.sv */
// load model for the headphone drivers
// assumes the bench commands a shorted load; a short is seen only while driven
`timescale 1ns/1ps
`default_nettype none

module osc_hp_load (
  // driver power from the block
  input  wire logic pwr_l,
  input  wire logic pwr_r,
  // fault commands from the bench
  input  wire logic fault_l,
  input  wire logic fault_r,
  // detector levels to the block
  output logic      hp_short_l,
  output logic      hp_short_r
);
  // an unpowered driver draws no current, so its short is not seen
  assign hp_short_l = fault_l & pwr_l;
  assign hp_short_r = fault_r & pwr_r;
endmodule : osc_hp_load

`default_nettype wire

/* File: tb/output_stage_control_tb.sv */
// self-checking bench for the output stage control block
// assumes the design files and the load model are compiled first
`include "osc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module output_stage_control_tb;
  logic       mclk, rst_b, reg_page, reg_wr, reg_rd, fault_l, fault_r;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_r;
  wire logic  hp_short_l, hp_short_r;
  logic       left_headphone_out_pwr_r, right_headphone_out_pwr_r;
  logic [3:0] left_headphone_out_gain_r, right_headphone_out_gain_r;
  logic       left_headphone_out_mute_r, right_headphone_out_mute_r;
  logic       left_headphone_out_ilim_r, right_headphone_out_ilim_r;
  logic [1:0] hp_common_mode_r;
  logic       hp_lineout_mode_r, dac_route_l_r, dac_route_r_r, spk_feed_l_r, spk_feed_r_r;
  logic [6:0] spk_vol_l_r, spk_vol_r_r;
  logic [9:0] spk_atten_l_r, spk_atten_r_r;
  logic       spk_mute_l_r, spk_mute_r_r;
  int         err_count, comparisons, cycles;
  localparam logic [6:0] OFS [7] = '{`OSC_OFS_HP_CTRL, `OSC_OFS_ROUTE, `OSC_OFS_SPK_L,
    `OSC_OFS_SPK_R, `OSC_OFS_HPG_L, `OSC_OFS_HPG_R, `OSC_OFS_HP_OPT};

  osc_output_ctrl u_osc_output_ctrl (.mclk, .rst_b, .reg_page, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_r, .hp_short_l, .hp_short_r, .left_headphone_out_pwr_r,
    .right_headphone_out_pwr_r, .left_headphone_out_gain_r, .right_headphone_out_gain_r,
    .left_headphone_out_mute_r, .right_headphone_out_mute_r, .left_headphone_out_ilim_r,
    .right_headphone_out_ilim_r, .hp_common_mode_r, .hp_lineout_mode_r, .dac_route_l_r,
    .dac_route_r_r, .spk_feed_l_r, .spk_feed_r_r, .spk_vol_l_r, .spk_vol_r_r,
    .spk_atten_l_r, .spk_atten_r_r, .spk_mute_l_r, .spk_mute_r_r);

  osc_hp_load u_osc_hp_load (.pwr_l(left_headphone_out_pwr_r),
    .pwr_r(right_headphone_out_pwr_r), .fault_l, .fault_r, .hp_short_l, .hp_short_r);

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic final_report;
    $display("Compares %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  // one write strobe, inputs changed at the falling edge
  task automatic wr(input logic pg, input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_page = pg;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  // one read strobe, data judged once registered
  task automatic rd(input logic pg, input logic [6:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_page = pg;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    chk(reg_rdata_r, exp);
  endtask : rd

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    foreach (OFS[i]) rd(1'b1, OFS[i], 8'h00);
    chk({left_headphone_out_pwr_r, spk_feed_l_r, dac_route_l_r}, 3'h0);
  endtask : t_reset

  task automatic t_route;
    wr(1'b1, `OSC_OFS_ROUTE, 8'h44);
    wr(1'b1, `OSC_OFS_HPG_L, 8'h36);
    wr(1'b1, `OSC_OFS_HPG_R, 8'h48);
    wr(1'b1, `OSC_OFS_HP_CTRL, 8'hD9);
    wr(1'b1, `OSC_OFS_HP_OPT, 8'h06);
    idle(3);
    chk({dac_route_l_r, dac_route_r_r}, 2'h3);
    chk({left_headphone_out_gain_r, left_headphone_out_mute_r}, 5'h0D);
    chk({right_headphone_out_gain_r, right_headphone_out_mute_r}, 5'h12);
    chk({left_headphone_out_pwr_r, right_headphone_out_pwr_r}, 2'h3);
    chk(hp_common_mode_r, 2'h3);
    chk(hp_lineout_mode_r, 1'b1);
    rd(1'b1, `OSC_OFS_HP_CTRL, 8'hD8);
    rd(1'b1, 7'h30, 8'h00);
    wr(1'b1, `OSC_OFS_HP_OPT, 8'h04);
    idle(3);
    chk(hp_lineout_mode_r, 1'b0);
  endtask : t_route

  task automatic t_volume;
    wr(1'b0, `OSC_OFS_SS_CTRL, 8'h03);
    wr(1'b1, `OSC_OFS_SPK_L, 8'h85);
    wr(1'b1, `OSC_OFS_SPK_R, 8'h7F);
    idle(5);
    chk({spk_mute_l_r, spk_feed_l_r, spk_vol_l_r}, 9'h085);
    chk(spk_atten_l_r, 10'h019);
    chk({spk_feed_r_r, spk_mute_r_r, spk_atten_r_r}, 12'h70F);
    chk(spk_vol_r_r, 7'h7F);
    wr(1'b1, `OSC_OFS_SPK_R, 8'hFF);
    idle(5);
    chk({spk_feed_r_r, spk_mute_r_r}, 2'h2);
  endtask : t_volume

  // each interval code paced from the 209-clock base, one step at a time
  task automatic t_step;
    wr(1'b0, `OSC_OFS_SS_CTRL, 8'h00);
    wr(1'b1, `OSC_OFS_SPK_L, 8'h87);
    idle(100);
    chk(spk_vol_l_r, 7'h05);
    idle(160);
    chk(spk_vol_l_r, 7'h06);
    idle(240);
    chk(spk_vol_l_r, 7'h07);
    idle(300);
    chk(spk_vol_l_r, 7'h07);
    wr(1'b0, `OSC_OFS_SS_CTRL, 8'h01);
    wr(1'b1, `OSC_OFS_SPK_L, 8'h86);
    idle(300);
    chk(spk_vol_l_r, 7'h07);
    idle(200);
    chk(spk_vol_l_r, 7'h06);
    wr(1'b0, `OSC_OFS_SS_CTRL, 8'h02);
    wr(1'b1, `OSC_OFS_SPK_L, 8'h85);
    idle(700);
    chk(spk_vol_l_r, 7'h06);
    idle(200);
    chk(spk_vol_l_r, 7'h05);
  endtask : t_step

  task automatic t_short;
    wr(1'b1, `OSC_OFS_HP_CTRL, 8'hC0);
    {fault_l, fault_r} = 2'h3;
    idle(6);
    chk({left_headphone_out_ilim_r, right_headphone_out_ilim_r, left_headphone_out_pwr_r,
      right_headphone_out_pwr_r}, 4'hF);
    rd(1'b1, `OSC_OFS_HP_CTRL, 8'hC1);
    {fault_l, fault_r} = 2'h0;
    idle(4);
    wr(1'b1, `OSC_OFS_HP_CTRL, 8'hC2);
    {fault_l, fault_r} = 2'h3;
    idle(6);
    chk({left_headphone_out_pwr_r, right_headphone_out_pwr_r}, 2'h0);
    rd(1'b1, `OSC_OFS_HP_CTRL, 8'h02);
    // two restarts in a row, below the safe limit of three
    wr(1'b1, `OSC_OFS_HP_CTRL, 8'hC2);
    idle(8);
    chk({left_headphone_out_pwr_r, right_headphone_out_pwr_r}, 2'h0);
    {fault_l, fault_r} = 2'h0;
    idle(4);
    wr(1'b1, `OSC_OFS_HP_CTRL, 8'hC2);
    idle(8);
    chk({left_headphone_out_pwr_r, right_headphone_out_pwr_r}, 2'h3);
    rd(1'b1, `OSC_OFS_HPG_L, 8'h36);
  endtask : t_short

  task automatic t_swreset;
    wr(1'b0, `OSC_OFS_SW_RST, 8'h01);
    idle(4);
    chk({dac_route_l_r, spk_feed_l_r, right_headphone_out_pwr_r}, 3'h0);
    rd(1'b1, `OSC_OFS_HPG_L, 8'h00);
  endtask : t_swreset

  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // cut a hang short well past the expected run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    {rst_b, reg_page, reg_wr, reg_rd, fault_l, fault_r} = 6'h00;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    idle(20);
    rst_b = 1'b1;
    t_reset();
    t_route();
    t_volume();
    t_step();
    t_short();
    t_swreset();
    final_report();
  end
endmodule : output_stage_control_tb

`default_nettype wire
